// >>> timing_nco.sv
// Purpose: timing oscillator, error detector and resampler pacing
// Assumes: reference clock edge and serial bits arrive synchronous to core_clk
// Notes: registers on a plain port, read data one cycle after read strobe
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module timing_nco #(
   parameter int ACC_W = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic reference_clock_input,
   input wire logic ext_sync,
   input wire logic offset_serial_bit,
   input wire logic offset_serial_valid,
   input wire logic resamp_in_valid,
   output logic sample_pulse,
   output logic [31:0] sample_phase,
   output logic resamp_out_valid,
   output logic [2:0] interp_factor,
   output logic error_serial_out,
   output logic error_serial_frame
);
   import timing_pkg::*;

   if (ACC_W != 32) begin
      $error("accumulator width must be 32");
   end

   logic [31:0] ctrl_q, center_q, phase_reg_q, div_q, center_act_q;
   logic [31:0] offset_shift_q, offset_act_q, acc_q, acc_d;
   logic [7:0] phase_act_q;
   logic [5:0] shift_cnt_q;
   logic [2:0] mode_q;
   logic carry;
   logic [32:0] sum;
   logic [31:0] incr;
   logic fstrobe, pstrobe;
   logic [DIV_W-1:0] osc_cnt_q, ref_cnt_q;
   logic [ERR_W-1:0] error_q, err_shift_q;
   logic [4:0] ser_cnt_q;
   logic ref_q, ref_edge;
   logic resamp_busy, rv;
   logic [2:0] ifac;
   sample_tick_s tick;

   function automatic logic [5:0] ofs_bits(input logic [1:0] sel);
      case (sel)
         2'h0: ofs_bits = 6'h08;
         2'h1: ofs_bits = 6'h10;
         2'h2: ofs_bits = 6'h18;
         default: ofs_bits = 6'h20;
      endcase
   endfunction

   assign fstrobe = reg_write && reg_addr == ADDR_FSTROBE;
   assign pstrobe = reg_write && reg_addr == ADDR_PSTROBE;

   // register writes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
         center_q <= CENTER_RESET;
         phase_reg_q <= 32'h0000_0000;
         div_q <= DIV_RESET;
         mode_q <= 3'h0;
      end else if (reg_write) begin
         if (reg_addr == ADDR_CTRL) begin
            ctrl_q <= reg_wdata;
         end else if (reg_addr == ADDR_CENTER) begin
            center_q <= reg_wdata;
         end else if (reg_addr == ADDR_PHASE) begin
            phase_reg_q <= {24'h00_0000, reg_wdata[PHASE_OFS_W-1:0]};
         end else if (reg_addr == ADDR_DIVIDERS) begin
            div_q <= {4'h0, reg_wdata[OSC_DIV_LO+:DIV_W], 4'h0, reg_wdata[REF_DIV_LO+:DIV_W]};
         end else if (reg_addr == ADDR_MODE) begin
            mode_q <= (reg_wdata[2:0] > 3'h5) ? 3'h0 : reg_wdata[2:0];
         end
      end
   end

   // serial offset frequency, msb first
   always_ff @(posedge core_clk) begin
      if (reset) begin
         offset_shift_q <= 32'h0000_0000;
         shift_cnt_q <= 6'h00;
         offset_act_q <= 32'h0000_0000;
      end else if (offset_serial_valid) begin
         if (shift_cnt_q + 6'h01 == ofs_bits(ctrl_q[CTRL_WIDTH_LO+:2])) begin
            offset_act_q <= {offset_shift_q[30:0], offset_serial_bit};
            shift_cnt_q <= 6'h00;
            offset_shift_q <= 32'h0000_0000;
         end else begin
            offset_shift_q <= {offset_shift_q[30:0], offset_serial_bit};
            shift_cnt_q <= shift_cnt_q + 6'h01;
         end
      end
   end

   // strobed transfer into use
   always_ff @(posedge core_clk) begin
      if (reset) begin
         center_act_q <= CENTER_RESET;
         phase_act_q <= 8'h00;
      end else begin
         if (fstrobe) begin
            center_act_q <= center_q;
         end
         if (pstrobe) begin
            phase_act_q <= phase_reg_q[PHASE_OFS_W-1:0];
         end
      end
   end

   // phase accumulator only
   assign incr = ctrl_q[CTRL_OFS_EN_BIT] ? center_act_q + offset_act_q : center_act_q;
   assign sum = {1'b0, acc_q} + {1'b0, incr};
   assign carry = sum[32];

   always_comb begin
      acc_d = sum[31:0];
      if (ctrl_q[CTRL_CLEAR_BIT]) begin
         acc_d = 32'h0000_0000;
      end else if (ctrl_q[CTRL_SYNC_BIT] && ext_sync) begin
         acc_d = 32'h0000_0000;
      end else if (fstrobe && ctrl_q[CTRL_LOAD_BIT]) begin
         acc_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         acc_q <= 32'h0000_0000;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sample_pulse <= 1'b0;
         sample_phase <= 32'h0000_0000;
      end else begin
         sample_pulse <= carry;
         sample_phase <= sum[31:0] + {phase_act_q, 24'h00_0000};
      end
   end

   assign tick = {sample_pulse, sample_phase};

   // timing error counters
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= reference_clock_input;
      end
   end
   assign ref_edge = reference_clock_input && !ref_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_cnt_q <= '0;
      end else if (carry) begin
         if (osc_cnt_q == '0) begin
            osc_cnt_q <= div_q[OSC_DIV_LO+:DIV_W];
         end else begin
            osc_cnt_q <= osc_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ref_cnt_q <= '0;
      end else if (ref_edge) begin
         if (ref_cnt_q == '0) begin
            ref_cnt_q <= div_q[REF_DIV_LO+:DIV_W];
         end else begin
            ref_cnt_q <= ref_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         error_q <= '0;
      end else if (ref_edge && ref_cnt_q == '0) begin
         error_q <= {4'h0, osc_cnt_q};
      end
   end

   // serial error output, msb first, 16 bits after each capture
   always_ff @(posedge core_clk) begin
      if (reset) begin
         err_shift_q <= '0;
         ser_cnt_q <= 5'h00;
         error_serial_out <= 1'b0;
         error_serial_frame <= 1'b0;
      end else if (ref_edge && ref_cnt_q == '0) begin
         err_shift_q <= {4'h0, osc_cnt_q};
         ser_cnt_q <= 5'h10;
         error_serial_out <= 1'b0;
         error_serial_frame <= 1'b0;
      end else if (ser_cnt_q != 5'h00) begin
         error_serial_out <= err_shift_q[ERR_W-1];
         error_serial_frame <= 1'b1;
         err_shift_q <= {err_shift_q[ERR_W-2:0], 1'b0};
         ser_cnt_q <= ser_cnt_q - 5'h01;
      end else begin
         error_serial_out <= 1'b0;
         error_serial_frame <= 1'b0;
      end
   end

   // read port
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         if (reg_addr == ADDR_CTRL) begin
            reg_rdata <= ctrl_q;
         end else if (reg_addr == ADDR_CENTER) begin
            reg_rdata <= center_q;
         end else if (reg_addr == ADDR_PHASE) begin
            reg_rdata <= phase_reg_q;
         end else if (reg_addr == ADDR_DIVIDERS) begin
            reg_rdata <= div_q;
         end else if (reg_addr == ADDR_ERROR) begin
            reg_rdata <= {16'h0000, error_q};
         end else if (reg_addr == ADDR_MODE) begin
            reg_rdata <= {29'h0, mode_q};
         end else if (reg_addr == ADDR_OFFSET) begin
            reg_rdata <= offset_act_q;
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   resamp_budget u_budget (
      .core_clk(core_clk),
      .reset(reset),
      .mode(resamp_mode_e'(mode_q)),
      .in_valid(resamp_in_valid),
      .tick(tick),
      .busy(resamp_busy),
      .out_valid(rv),
      .interp_factor(ifac)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         resamp_out_valid <= 1'b0;
         interp_factor <= 3'h1;
      end else begin
         resamp_out_valid <= rv;
         interp_factor <= ifac;
      end
   end

   // loop correction enters through the serial offset path

   sequence ser_frame_s;
      ##1 error_serial_frame [*8];
   endsequence

   freq_strobe_a: assert property (@(posedge core_clk) disable iff (reset)
      fstrobe |=> center_act_q == $past(center_q))
      else $error("frequency not applied on strobe");
   phase_strobe_a: assert property (@(posedge core_clk) disable iff (reset)
      pstrobe |=> phase_act_q == $past(phase_reg_q[PHASE_OFS_W-1:0]))
      else $error("phase not applied on strobe");
   acc_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_q[CTRL_CLEAR_BIT] [*2] |-> acc_q == 32'h0000_0000)
      else $error("accumulator not held clear");
   pulse_carry_a: assert property (@(posedge core_clk) disable iff (reset)
      carry |=> sample_pulse)
      else $error("sample pulse missing after carry");
   osc_reload_a: assert property (@(posedge core_clk) disable iff (reset)
      (carry && osc_cnt_q == '0) |=> osc_cnt_q == $past(div_q[OSC_DIV_LO+:DIV_W]))
      else $error("oscillator counter not reloaded");
   ref_reload_a: assert property (@(posedge core_clk) disable iff (reset)
      (ref_edge && ref_cnt_q == '0) |=> ref_cnt_q == $past(div_q[REF_DIV_LO+:DIV_W]))
      else $error("reference counter not reloaded");
   err_capture_a: assert property (@(posedge core_clk) disable iff (reset)
      (ref_edge && ref_cnt_q == '0) |=> error_q == {4'h0, $past(osc_cnt_q)})
      else $error("error not captured at reference reload");
   offset_add_a: assert property (@(posedge core_clk) disable iff (reset)
      (!ctrl_q[CTRL_OFS_EN_BIT] && ctrl_q[CTRL_LOAD_BIT+:2] == 2'h0 && !ctrl_q[CTRL_SYNC_BIT])
      |=> acc_q == $past(acc_q) + $past(center_act_q))
      else $error("offset added while disabled");
   serial_frame_a: assert property (@(posedge core_clk) disable iff (reset)
      (ref_edge && ref_cnt_q == '0) |=> ser_frame_s)
      else $error("serial error frame too short");
endmodule
`default_nettype wire

// >>> timing_pkg.sv
// Purpose: constants and carriers for the timing oscillator and error detector
// Assumes: single back-end processing clock, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
//
// Overview of operation
// - resampler spends 0, 6, 7, 13, 17 or 23 cycles per input by mode
// - each enabled halfband doubles rate: factor 2 for one, 4 for two
// - with polyphase in path, output pacing follows oscillator sample pulses
// - oscillator gives resampler a sample pulse plus its accumulator phase
// - oscillator has phase accumulator only, no sine or cosine stage
// - control bit 5 enables external sync of the oscillator
// - control bits 3-4 select serial offset frequency word length
// - control bit 2 adds offset frequency to center frequency
// - control bit 1 holds accumulator clear while set
// - control bit 0 loads accumulator on update instead of accumulating
// - center frequency register forms the base phase increment
// - eight-bit phase offset in bits 0-7 is added to oscillator phase
// - frequency strobe write moves new frequency into use
// - phase strobe write moves new phase offset into use
// - error value comes from comparing two programmable counters
// - one counter counts oscillator carries, other counts reference clock
// - oscillator divide preload sits in error control bits 16-27
// - reference divide preload sits in error control bits 0-11
// - sixteen-bit error is on serial output and readable by processor
package timing_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'hB;
   localparam logic [3:0] ADDR_CENTER = 4'hC;
   localparam logic [3:0] ADDR_PHASE = 4'hD;
   localparam logic [3:0] ADDR_FSTROBE = 4'hE;
   localparam logic [3:0] ADDR_PSTROBE = 4'hF;
   localparam logic [3:0] ADDR_DIVIDERS = 4'h2;
   localparam logic [3:0] ADDR_ERROR = 4'h3;
   localparam logic [3:0] ADDR_MODE = 4'h4;
   localparam logic [3:0] ADDR_OFFSET = 4'h5;
   localparam int CTRL_SYNC_BIT = 5;
   localparam int CTRL_WIDTH_LO = 3;
   localparam int CTRL_OFS_EN_BIT = 2;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int CTRL_LOAD_BIT = 0;
   localparam int OSC_DIV_LO = 16;
   localparam int REF_DIV_LO = 0;
   localparam int DIV_W = 12;
   localparam int ERR_W = 16;
   localparam int PHASE_OFS_W = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CENTER_RESET = 32'h0000_0000;
   localparam logic [31:0] DIV_RESET = 32'h0000_0000;
   localparam logic [4:0] CYC_BYPASS = 5'h00;
   localparam logic [4:0] CYC_POLY = 5'h06;
   localparam logic [4:0] CYC_HB1 = 5'h07;
   localparam logic [4:0] CYC_POLY_HB1 = 5'h0D;
   localparam logic [4:0] CYC_HB2 = 5'h11;
   localparam logic [4:0] CYC_POLY_HB2 = 5'h17;
   typedef enum logic [2:0] {
      MODE_BYPASS, MODE_POLY, MODE_HB1, MODE_POLY_HB1, MODE_HB2, MODE_POLY_HB2
   } resamp_mode_e;
   typedef struct packed {
      logic pulse;
      logic [31:0] phase;
   } sample_tick_s;
endpackage

// >>> resamp_budget.sv
// Purpose: resampler cycle budget and output pacing per mode
// Assumes: one input sample strobe at a time, budget counted from its arrival
// Notes: busy until the mode's cycle count has passed
`timescale 1ns/1ns
`default_nettype none
module resamp_budget (
   input wire logic core_clk,
   input wire logic reset,
   input wire timing_pkg::resamp_mode_e mode,
   input wire logic in_valid,
   input wire timing_pkg::sample_tick_s tick,
   output logic busy,
   output logic out_valid,
   output logic [2:0] interp_factor
);
   import timing_pkg::*;
   logic [4:0] cnt_q;
   logic [1:0] burst_q;
   logic poly;

   function automatic logic [4:0] budget(input resamp_mode_e m);
      case (m)
         MODE_POLY: budget = CYC_POLY;
         MODE_HB1: budget = CYC_HB1;
         MODE_POLY_HB1: budget = CYC_POLY_HB1;
         MODE_HB2: budget = CYC_HB2;
         MODE_POLY_HB2: budget = CYC_POLY_HB2;
         default: budget = CYC_BYPASS;
      endcase
   endfunction

   function automatic logic [2:0] factor(input resamp_mode_e m);
      case (m)
         MODE_HB1, MODE_POLY_HB1: factor = 3'h2;
         MODE_HB2, MODE_POLY_HB2: factor = 3'h4;
         default: factor = 3'h1;
      endcase
   endfunction

   assign poly = (mode == MODE_POLY) || (mode == MODE_POLY_HB1) || (mode == MODE_POLY_HB2);
   assign busy = cnt_q != 5'h00;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_q <= 5'h00;
      end else if (in_valid && !busy) begin
         cnt_q <= budget(mode);
      end else if (busy) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         interp_factor <= 3'h1;
      end else begin
         interp_factor <= factor(mode);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         burst_q <= 2'h0;
      end else if (poly) begin
         out_valid <= tick.pulse;
         burst_q <= 2'h0;
      end else if (in_valid && !busy) begin
         out_valid <= 1'b1;
         burst_q <= 2'(factor(mode) - 3'h1);
      end else if (burst_q != 2'h0) begin
         out_valid <= 1'b1;
         burst_q <= burst_q - 2'h1;
      end else begin
         out_valid <= 1'b0;
      end
   end

   sequence burst4_s;
      out_valid [*4];
   endsequence

   budget_load_a: assert property (@(posedge core_clk) disable iff (reset)
      (in_valid && !busy && mode == MODE_POLY_HB2) |=> cnt_q == CYC_POLY_HB2)
      else $error("budget not 23 cycles");
   hb2_burst_a: assert property (@(posedge core_clk) disable iff (reset)
      (in_valid && !busy && mode == MODE_HB2) |=> burst4_s)
      else $error("two halfbands did not give four outputs");
   poly_pace_a: assert property (@(posedge core_clk) disable iff (reset)
      (poly && $past(poly)) |-> out_valid == $past(tick.pulse))
      else $error("polyphase output not paced by oscillator");
endmodule
`default_nettype wire

// >>> timing_partner.sv
// Purpose: far-side model: reference clock source and external loop filter
// Assumes: drives right after rising edges of core_clk
// Notes: reference line idles low outside bursts
`timescale 1ns/1ns
`default_nettype none
module timing_partner (
   input wire logic core_clk,
   output logic reference_clock_input,
   output logic offset_serial_bit,
   output logic offset_serial_valid
);
   initial begin
      reference_clock_input = 1'b0;
      offset_serial_bit = 1'b0;
      offset_serial_valid = 1'b0;
   end
   // reference edges, two cycles high, five low
   task automatic ref_pulses(input int n);
      repeat (n) begin
         @(posedge core_clk);
         reference_clock_input <= 1'b1;
         repeat (2) @(posedge core_clk);
         reference_clock_input <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   // loop filter correction word, msb first
   task automatic send_offset(input int nbits, input logic [31:0] word);
      for (int i = nbits - 1; i >= 0; i--) begin
         @(posedge core_clk);
         offset_serial_bit <= word[i];
         offset_serial_valid <= 1'b1;
      end
      @(posedge core_clk);
      offset_serial_valid <= 1'b0;
      offset_serial_bit <= ~word[0];
   endtask
endmodule
`default_nettype wire

// >>> tb_timing_nco_and_error_detector.sv
// Purpose: self-checking bench for the timing oscillator and error detector
// Assumes: partner supplies reference edges and serial offset words
// Notes: register reads and serial frames checked against queued notes
`timescale 1ns/1ns
`default_nettype none
module tb_timing_nco_and_error_detector;
   import timing_pkg::*;
   localparam int MODES[6] = '{0, 2, 4, 1, 3, 5};
   localparam int FACT[6] = '{1, 2, 4, 1, 2, 4};
   localparam int OUTS[6] = '{1, 2, 4, 0, 0, 0};
   logic core_clk, reset, reg_write, reg_read, ext_sync, resamp_in_valid;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, sample_phase, seed, w;
   logic reference_clock_input, offset_serial_bit, offset_serial_valid;
   logic sample_pulse, resamp_out_valid, error_serial_out, error_serial_frame;
   logic [2:0] interp_factor;
   logic [31:0] exp_q[$];
   logic [15:0] ser_q[$];
   logic [15:0] ser_sh;
   logic rd_pend, frame_q;
   int err_count, compares, pulse_count, out_count, c0, n, m;

   timing_nco DUT (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .reference_clock_input(reference_clock_input),
      .ext_sync(ext_sync), .offset_serial_bit(offset_serial_bit),
      .offset_serial_valid(offset_serial_valid), .resamp_in_valid(resamp_in_valid),
      .sample_pulse(sample_pulse), .sample_phase(sample_phase),
      .resamp_out_valid(resamp_out_valid), .interp_factor(interp_factor),
      .error_serial_out(error_serial_out), .error_serial_frame(error_serial_frame));
   timing_partner partner (.core_clk(core_clk), .reference_clock_input(reference_clock_input),
      .offset_serial_bit(offset_serial_bit), .offset_serial_valid(offset_serial_valid));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_read <= 1'b0;
   endtask
   // pulses counted over a forty-cycle window
   task automatic rate(input int e);
      c0 = pulse_count;
      cycles(40);
      chk(32'(pulse_count - c0), 32'(e));
   endtask
   // one input, or two with a gap, then count outputs
   task automatic resamp(input int gap, input int e);
      c0 = out_count;
      for (int k = 0; k < ((gap < 0) ? 1 : 2); k++) begin
         @(posedge core_clk);
         resamp_in_valid <= 1'b1;
         @(posedge core_clk);
         resamp_in_valid <= 1'b0;
         if (gap > 0) cycles(gap);
      end
      cycles(50);
      chk(32'(out_count - c0), 32'(e));
   endtask

   // watcher: counts pulses, checks read data and serial frames
   always @(posedge core_clk) begin
      if (sample_pulse === 1'b1) pulse_count <= pulse_count + 1;
      if (resamp_out_valid === 1'b1) out_count <= out_count + 1;
      if (rd_pend === 1'b1) chk(reg_rdata, exp_q.pop_front());
      rd_pend <= reg_read;
      frame_q <= error_serial_frame;
      if (error_serial_frame === 1'b1) ser_sh <= {ser_sh[14:0], error_serial_out};
      if (frame_q === 1'b1 && error_serial_frame === 1'b0) begin
         chk({16'h0000, ser_sh}, {16'h0000, ser_q.pop_front()});
      end
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      err_count++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      ext_sync = 1'b0;
      resamp_in_valid = 1'b0;
      rd_pend = 1'b0;
      frame_q = 1'b0;
      ser_sh = 16'h0000;
      seed = 32'h7884;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) rd(4'(MODES[i] + 10), 32'h0000_0000);
      rd(ADDR_DIVIDERS, 32'h0000_0000);
      rd(ADDR_ERROR, 32'h0000_0000);
      wr(4'h0, 32'hFFFF_FFFF);
      rd(4'h0, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(ADDR_CENTER, seed);
         rd(ADDR_CENTER, seed);
         w = seed & 32'h0FFF_0FFF;
         wr(ADDR_DIVIDERS, w);
         rd(ADDR_DIVIDERS, w);
         wr(ADDR_PHASE, seed & 32'h0000_00FF);
         rd(ADDR_PHASE, seed & 32'h0000_00FF);
      end
      // error capture from a counted number of carries
      wr(ADDR_DIVIDERS, 32'h0005_0002);
      wr(ADDR_CENTER, 32'h4000_0000);
      c0 = pulse_count;
      wr(ADDR_FSTROBE, 32'h0000_0000);
      cycles(37);
      wr(ADDR_CTRL, 32'h0000_0002);
      cycles(4);
      n = pulse_count - c0;
      cycles(20);
      chk(32'(pulse_count - c0), 32'(n));
      m = (n == 0) ? 0 : 5 - ((n - 1) % 6);
      ser_q.push_back(16'(m));
      partner.ref_pulses(1);
      cycles(30);
      rd(ADDR_ERROR, 32'(m));
      chk(32'(ser_q.size()), 32'h0000_0000);
      // reference counter divides by its preload plus one
      ser_q.push_back(16'(m));
      partner.ref_pulses(2);
      cycles(30);
      chk(32'(ser_q.size()), 32'h0000_0001);
      partner.ref_pulses(1);
      cycles(30);
      chk(32'(ser_q.size()), 32'h0000_0000);
      rd(ADDR_ERROR, 32'(m));
      // rate from center and offset frequency
      wr(ADDR_CTRL, 32'h0000_0000);
      cycles(10);
      rate(10);
      wr(ADDR_CTRL, 32'h0000_0018);
      partner.send_offset(32, 32'h2000_0000);
      rd(ADDR_OFFSET, 32'h2000_0000);
      wr(ADDR_CENTER, 32'h2000_0000);
      wr(ADDR_FSTROBE, 32'h0000_0000);
      cycles(10);
      rate(5);
      wr(ADDR_CTRL, 32'h0000_001C);
      cycles(10);
      rate(10);
      ext_sync <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_003C);
      cycles(4);
      rate(0);
      wr(ADDR_CTRL, 32'h0000_001C);
      cycles(10);
      rate(10);
      ext_sync <= 1'b0;
      // phase offset path
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_CENTER, 32'h0000_0000);
      wr(ADDR_FSTROBE, 32'h0000_0000);
      wr(ADDR_PHASE, 32'h0000_0040);
      cycles(3);
      chk(sample_phase, 32'h0000_0000);
      wr(ADDR_PSTROBE, 32'h0000_0000);
      cycles(3);
      chk(sample_phase, 32'h4000_0000);
      // shorter serial offset words
      for (int j = 0; j < 3; j++) begin
         seed = lfsr(seed);
         w = seed >> (24 - 8 * j);
         wr(ADDR_CTRL, 32'(j << 3));
         partner.send_offset(8 * (j + 1), w);
         rd(ADDR_OFFSET, w);
      end
      // resampler budget with the oscillator held cleared
      wr(ADDR_CTRL, 32'h0000_0002);
      wr(ADDR_MODE, 32'h0000_0002);
      resamp(1, 2);
      wr(ADDR_MODE, 32'h0000_0004);
      resamp(10, 4);
      wr(ADDR_MODE, 32'h0000_0000);
      resamp(0, 2);
      wr(ADDR_MODE, 32'h0000_0007);
      rd(ADDR_MODE, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_MODE, 32'(MODES[i]));
         rd(ADDR_MODE, 32'(MODES[i]));
         cycles(2);
         chk(32'(interp_factor), 32'(FACT[i]));
         resamp(-1, OUTS[i]);
      end
      // polyphase output paced by a running oscillator, one per four cycles
      wr(ADDR_CENTER, 32'h4000_0000);
      wr(ADDR_FSTROBE, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_MODE, 32'h0000_0001);
      cycles(10);
      resamp(-1, 13);
      cycles(3);
      report_and_stop();
   end
endmodule
`default_nettype wire
